/* tb/ccim_cycle_model_asserts.sv */
// checker of the cycle sequencer, seeing only its top ports.
// assumes one clock domain and the constants header on the include path.
`include "ccim_consts.vh"
module ccim_cycle_model_asserts
(
   input logic MCLK_I,
   input logic SYS_RST_I,
   input logic ISSUE_VALID_I,
   input logic ISSUE_READY_O,
   input logic [3:0] ISSUE_CLASS_I,
   input logic [31:0] INSTR_I,
   input logic COMPRESSED_I,
   input logic PC_DEST_I,
   input logic REG_SHIFT_I,
   input logic FLAGS_ONLY_I,
   input logic MEM_WAIT_I,
   input logic [3:0] MUL_OPND_SEL_O,
   input logic FETCH_EN_O,
   input logic INTERLOCK_O,
   input logic XFER_VALID_O,
   input logic [3:0] XFER_REG_O,
   input logic DONE_O,
   input logic [7:0] CYCLE_COUNT_O
);
   timeunit 1ns;
   timeprecision 1ps;
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (SYS_RST_I);
   wire acc = ISSUE_VALID_I && ISSUE_READY_O; // instruction taken at this edge
   wire is_mul = (ISSUE_CLASS_I == `CCIM_CLS_MUL) || (ISSUE_CLASS_I == `CCIM_CLS_LMUL);
   // one-cycle instruction finishes two edges after accept
   property one_cycle(logic c);
      acc && c ##1 !MEM_WAIT_I |=> DONE_O && CYCLE_COUNT_O == 8'h01;
   endproperty
   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   a_fetch_in_lock: assert property (INTERLOCK_O |-> !FETCH_EN_O)
      else $error("fetch enabled during interlock");
   a_fetch_in_wait: assert property (MEM_WAIT_I |-> !FETCH_EN_O)
      else $error("fetch enabled during memory wait");
   a_opnd_sel_full: assert property (acc && is_mul && !COMPRESSED_I |-> MUL_OPND_SEL_O == INSTR_I[11:8])
      else $error("wrong operand select, full set");
   a_opnd_sel_short: assert property (acc && is_mul && COMPRESSED_I |-> MUL_OPND_SEL_O == {1'b0, INSTR_I[2:0]})
      else $error("wrong operand select, compressed set");
   a_store_one: assert property (one_cycle(ISSUE_CLASS_I == `CCIM_CLS_STORE))
      else $error("store not one cycle");
   a_data_one: assert property (one_cycle(ISSUE_CLASS_I == `CCIM_CLS_DATA && !PC_DEST_I && !REG_SHIFT_I))
      else $error("plain data op not one cycle");
   a_status_one: assert property (one_cycle(ISSUE_CLASS_I == `CCIM_CLS_MRS || (ISSUE_CLASS_I == `CCIM_CLS_MSR && FLAGS_ONLY_I)))
      else $error("status access not one cycle");
   a_load_pc_five: assert property (acc && ISSUE_CLASS_I == `CCIM_CLS_LOAD && PC_DEST_I ##1 !MEM_WAIT_I [*5] |=> DONE_O && CYCLE_COUNT_O == 8'h05)
      else $error("load to pc not five cycles");
   a_xfer_rising: assert property ($past(XFER_VALID_O) && !$past(DONE_O) && XFER_VALID_O |-> XFER_REG_O > $past(XFER_REG_O))
      else $error("list registers out of order");
   // ---------------------------------------------------------------
   // covers
   // ---------------------------------------------------------------
   c_mload: cover property (acc && ISSUE_CLASS_I == `CCIM_CLS_MLOAD);
   c_lock: cover property (INTERLOCK_O);
   c_wait: cover property (MEM_WAIT_I && !FETCH_EN_O);
endmodule

/* tb/ccim_cycle_model_bench.sv */
// self-checking bench: random instructions against a length model.
// assumes the partner model supplies wait, busy and operand values.
`include "ccim_consts.vh"
module ccim_cycle_model_bench;
   timeunit 1ns;
   timeprecision 1ps;
   // ---------------------------------------------------------------
   // signals
   // ---------------------------------------------------------------
   logic MCLK_I = 1'b0;
   logic SYS_RST_I = 1'b1;
   logic ISSUE_VALID_I = 1'b0;
   logic [3:0] ISSUE_CLASS_I = 4'h0;
   logic [31:0] INSTR_I = 32'h0;
   logic COMPRESSED_I = 1'b0, PC_DEST_I = 1'b0, REG_SHIFT_I = 1'b0, SUB_WORD_I = 1'b0;
   logic FLAGS_ONLY_I = 1'b0, UNSIGNED_MUL_I = 1'b0;
   logic [3:0] LOAD_DEST_I = 4'h0, NEXT_SRC_A_I = 4'h0, NEXT_SRC_B_I = 4'h0;
   logic [15:0] REG_LIST_I = 16'h1;
   logic [4:0] CP_WORDS_I = 5'h1;
   logic [1:0] NEXT_SRC_VALID_I = 2'h0;
   logic [3:0] wcnt = 4'h0, bcnt = 4'h0; // partner wait and busy counts
   wire ISSUE_READY_O, MEM_WAIT_I, CP_BUSY_I, FETCH_EN_O, INTERLOCK_O, XFER_VALID_O, DONE_O;
   wire [3:0] MUL_OPND_SEL_O, XFER_REG_O;
   wire [31:0] MUL_OPND_I;
   wire [1:0] IBUS_CYC_O, DBUS_CYC_O;
   wire [7:0] CYCLE_COUNT_O;
   int error_cnt = 0, checks = 0, ilk = 0; // ilk: interlock cycles seen
   int dn = 0, dc = 0, isn = 0; // data N, data C and instruction S cycles seen
   logic [31:0] seed = 32'ha064;
   logic [3:0] xq [$]; // list registers reported
   ccim_cycle_model ccim_cycle_model_i (.MCLK_I, .SYS_RST_I, .ISSUE_VALID_I, .ISSUE_READY_O,
      .ISSUE_CLASS_I, .INSTR_I, .COMPRESSED_I, .PC_DEST_I, .REG_SHIFT_I, .SUB_WORD_I,
      .FLAGS_ONLY_I, .UNSIGNED_MUL_I, .LOAD_DEST_I, .REG_LIST_I, .CP_WORDS_I, .MUL_OPND_SEL_O,
      .MUL_OPND_I, .NEXT_SRC_A_I, .NEXT_SRC_B_I, .NEXT_SRC_VALID_I, .MEM_WAIT_I, .CP_BUSY_I,
      .FETCH_EN_O, .INTERLOCK_O, .IBUS_CYC_O, .DBUS_CYC_O, .XFER_VALID_O, .XFER_REG_O,
      .DONE_O, .CYCLE_COUNT_O);
   ccim_mem_partner ccim_mem_partner_i (.clk_i(MCLK_I), .rst_i(SYS_RST_I),
      .take_i(ISSUE_VALID_I && ISSUE_READY_O), .wait_cnt_i(wcnt), .busy_cnt_i(bcnt),
      .sel_i(MUL_OPND_SEL_O), .mem_wait_o(MEM_WAIT_I), .cp_busy_o(CP_BUSY_I), .opnd_o(MUL_OPND_I));
   // ---------------------------------------------------------------
   // clock and monitor of transfers and interlocks
   // ---------------------------------------------------------------
   initial forever #25 MCLK_I = ~MCLK_I;
   always @(posedge MCLK_I)
   begin
      if (XFER_VALID_O === 1'b1) xq.push_back(XFER_REG_O);
      if (INTERLOCK_O === 1'b1) ilk++;
      if (DBUS_CYC_O === `CCIM_BUS_N) dn++;
      if (DBUS_CYC_O === `CCIM_BUS_C) dc++;
      if (IBUS_CYC_O === `CCIM_BUS_S) isn++;
   end
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // early-termination term from the upper bytes of the operand
   function automatic int mterm(logic [31:0] v, logic u);
      for (int k = 1; k < 4; k++)
         if ((v >> (8 * k)) == 0 || (!u && ($signed(v) >>> (8 * k)) == -1)) return k;
      return 4;
   endfunction
   function automatic int exp_len(logic used, int n);
      logic [31:0] v;
      v = ccim_mem_partner_i.rf[COMPRESSED_I ? {1'b0, INSTR_I[2:0]} : INSTR_I[11:8]];
      case (ISSUE_CLASS_I)
         `CCIM_CLS_DATA: return 1 + REG_SHIFT_I + 2 * PC_DEST_I;
         `CCIM_CLS_LOAD: return PC_DEST_I ? 5 : 1 + (used ? (SUB_WORD_I ? 2 : 1) : 0);
         `CCIM_CLS_MLOAD: return (REG_LIST_I[15] ? n + 4 : (n == 1 ? 2 : n)) + used;
         `CCIM_CLS_MSTORE: return (n == 1) ? 2 : n;
         `CCIM_CLS_WSWAP: return 2 + used;
         `CCIM_CLS_BSWAP: return 3;
         `CCIM_CLS_CLDST: return CP_WORDS_I;
         `CCIM_CLS_MRC: return 1 + used;
         `CCIM_CLS_MSR: return FLAGS_ONLY_I ? 1 : 3;
         `CCIM_CLS_MUL: return 2 + mterm(v, 1'b0);
         `CCIM_CLS_LMUL: return 3 + mterm(v, UNSIGNED_MUL_I);
         default: return 1; // store, cdp, core_to_coproc, status read
      endcase
   endfunction
   task automatic cmp_val(string what, logic [31:0] exp, logic [31:0] got);
      checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("BAD %s expected %0d seen %0d", what, exp, got);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // ---------------------------------------------------------------
   // one random instruction, issued alone and checked when done
   // ---------------------------------------------------------------
   task automatic run_one(int idx);
      int n, exp, dst, k, j;
      logic used, cp, ml;
      logic [31:0] r, q;
      r = xs();
      q = xs();
      ISSUE_CLASS_I = 4'(r % 15);
      INSTR_I = xs();
      {COMPRESSED_I, PC_DEST_I, REG_SHIFT_I, SUB_WORD_I, FLAGS_ONLY_I, UNSIGNED_MUL_I} = q[29:24];
      REG_LIST_I = q[4] ? (16'h0001 << q[8:5]) : (16'(xs()) | 16'h0001);
      CP_WORDS_I = 5'(q[11:10]) + 5'h01;
      LOAD_DEST_I = q[15:12];
      n = $countones(REG_LIST_I);
      ml = (ISSUE_CLASS_I == `CCIM_CLS_MLOAD);
      dst = LOAD_DEST_I;
      for (k = 0; k < 15; k++) if (ml && REG_LIST_I[k]) dst = k;
      NEXT_SRC_A_I = q[16] ? 4'(dst) : r[23:20];
      NEXT_SRC_B_I = q[17] ? 4'(dst) : r[19:16];
      NEXT_SRC_VALID_I = q[19:18];
      if (ml && (REG_LIST_I[15] || n == 1)) NEXT_SRC_VALID_I = 2'h0;
      used = (NEXT_SRC_VALID_I[0] && NEXT_SRC_A_I == dst) || (NEXT_SRC_VALID_I[1] && NEXT_SRC_B_I == dst);
      cp = (ISSUE_CLASS_I >= `CCIM_CLS_CDP) && (ISSUE_CLASS_I <= `CCIM_CLS_MRC);
      bcnt = cp ? 4'(r[27:26]) : 4'h0;
      wcnt = (cp || q[1:0] == 2'h3) ? 4'h0 : 4'(q[1:0]);
      exp = exp_len(used, n) + bcnt + wcnt;
      ilk = 0;
      dn = 0;
      dc = 0;
      isn = 0;
      ISSUE_VALID_I = 1'b1;
      // ready is looked at mid-cycle, the request is taken at the next edge
      @(negedge MCLK_I);
      while (ISSUE_READY_O !== 1'b1) @(negedge MCLK_I);
      @(posedge MCLK_I);
      #1 ISSUE_VALID_I = 1'b0;
      k = 0;
      do begin @(negedge MCLK_I); k++; end while (DONE_O !== 1'b1 && k < 200);
      // a missing done pulse is a hang and counts against the run
      if (DONE_O !== 1'b1) error_cnt++;
      cmp_val("cycle count", exp, CYCLE_COUNT_O);
      if (ISSUE_CLASS_I == `CCIM_CLS_LOAD && !PC_DEST_I)
         cmp_val("interlock cycles", used ? (SUB_WORD_I ? 2 : 1) : 0, ilk);
      @(posedge MCLK_I);
      #1;
      j = ((PC_DEST_I && ISSUE_CLASS_I <= `CCIM_CLS_LOAD) || (ml && REG_LIST_I[15])) ? 2 : 1;
      cmp_val("instruction S cycles", j, isn);
      case (ISSUE_CLASS_I)
         `CCIM_CLS_LOAD, `CCIM_CLS_STORE, `CCIM_CLS_MSTORE, `CCIM_CLS_CLDST: j = 1;
         `CCIM_CLS_WSWAP, `CCIM_CLS_BSWAP: j = 2;
         `CCIM_CLS_MLOAD: j = (n == 1 && !REG_LIST_I[15]) ? 0 : 1;
         default: j = 0;
      endcase
      cmp_val("data N cycles", j, dn);
      j = (ISSUE_CLASS_I == `CCIM_CLS_MCR || ISSUE_CLASS_I == `CCIM_CLS_MRC) ? 1 : 0;
      cmp_val("coprocessor cycles", j, dc);
      if (ml || ISSUE_CLASS_I == `CCIM_CLS_MSTORE)
      begin
         cmp_val("transfer count", n, xq.size());
         j = 0;
         for (k = 0; k < 16; k++)
            if (REG_LIST_I[k] && j < xq.size())
            begin
               cmp_val("transfer register", k, xq[j]);
               j++;
            end
      end
      xq.delete();
      $display("test %0d class %0h cycles %0d finished", idx, ISSUE_CLASS_I, exp);
   endtask
   // ---------------------------------------------------------------
   // main sequence and watchdog
   // ---------------------------------------------------------------
   initial
   begin
      for (int k = 0; k < 16; k++)
      begin
         q_fill(k);
      end
      repeat (3) @(posedge MCLK_I);
      #1 SYS_RST_I = 1'b0;
      for (int t = 0; t < 200; t++) run_one(t);
      give_verdict();
   end
   // operands whose upper bytes are sign or zero fill of varying length
   task automatic q_fill(int k);
      logic [31:0] v;
      v = xs() >> (8 * ((k / 2) % 4));
      ccim_mem_partner_i.rf[k] = k[0] ? ~v : v;
   endtask
   initial
   begin
      #(200 * 40 * 50);
      error_cnt++;
      give_verdict();
   end
endmodule
bind ccim_cycle_model ccim_cycle_model_asserts ccim_cycle_model_asserts_i (.MCLK_I, .SYS_RST_I,
   .ISSUE_VALID_I, .ISSUE_READY_O, .ISSUE_CLASS_I, .INSTR_I, .COMPRESSED_I, .PC_DEST_I,
   .REG_SHIFT_I, .FLAGS_ONLY_I, .MEM_WAIT_I, .MUL_OPND_SEL_O, .FETCH_EN_O, .INTERLOCK_O,
   .XFER_VALID_O, .XFER_REG_O, .DONE_O, .CYCLE_COUNT_O);

/* tb/ccim_mem_partner.sv */
// far-side model: memory wait, coprocessor busy-wait and operand registers.
// assumes take_i marks the edge at which the sequencer accepts an instruction.
module ccim_mem_partner
(
   input logic clk_i,
   input logic rst_i,
   input logic take_i,
   input logic [3:0] wait_cnt_i,
   input logic [3:0] busy_cnt_i,
   input logic [3:0] sel_i,
   output logic mem_wait_o,
   output logic cp_busy_o,
   output logic [31:0] opnd_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   logic [31:0] rf [16]; // operand registers, filled by the bench
   logic [3:0] wait_left; // wait cycles still to hold
   logic [3:0] busy_left; // busy-wait cycles still to hold
   // operand follows the select in the same cycle
   assign opnd_o = rf[sel_i];
   assign mem_wait_o = (wait_left != 4'h0);
   assign cp_busy_o = (busy_left != 4'h0);
   // counters load at accept and run down one a cycle
   always @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         wait_left <= 4'h0;
         busy_left <= 4'h0;
      end
      else if (take_i)
      begin
         wait_left <= wait_cnt_i;
         busy_left <= busy_cnt_i;
      end
      else
      begin
         wait_left <= (wait_left != 4'h0) ? wait_left - 4'h1 : 4'h0;
         busy_left <= (busy_left != 4'h0) ? busy_left - 4'h1 : 4'h0;
      end
   end
endmodule

/* verilog/ccim_consts.vh */
// constants for the cycle and interlock sequencer: instruction classes,
// bus cycle codes, cycle counts and instruction field positions.
// assumes it is included once per compile unit by its bare name.
`ifndef CCIM_CONSTS_VH
`define CCIM_CONSTS_VH
// ---------------------------------------------------------------
// instruction classes presented by decode
// ---------------------------------------------------------------
`define CCIM_CLS_DATA 4'h0
`define CCIM_CLS_LOAD 4'h1
`define CCIM_CLS_STORE 4'h2
`define CCIM_CLS_MLOAD 4'h3
`define CCIM_CLS_MSTORE 4'h4
`define CCIM_CLS_WSWAP 4'h5
`define CCIM_CLS_BSWAP 4'h6
`define CCIM_CLS_CDP 4'h7
`define CCIM_CLS_CLDST 4'h8
`define CCIM_CLS_MCR 4'h9
`define CCIM_CLS_MRC 4'ha
`define CCIM_CLS_MRS 4'hb
`define CCIM_CLS_MSR 4'hc
`define CCIM_CLS_MUL 4'hd
`define CCIM_CLS_LMUL 4'he
// ---------------------------------------------------------------
// bus cycle codes: internal, sequential, nonsequential, coprocessor
// ---------------------------------------------------------------
`define CCIM_BUS_I 2'h0
`define CCIM_BUS_S 2'h1
`define CCIM_BUS_N 2'h2
`define CCIM_BUS_C 2'h3
// ---------------------------------------------------------------
// cycle counts (6-bit lengths)
// ---------------------------------------------------------------
`define CCIM_LEN_ONE 6'h01
`define CCIM_LEN_TWO 6'h02
`define CCIM_LEN_THREE 6'h03
`define CCIM_LEN_LOADPC 6'h05
`define CCIM_LEN_PCEXTRA 6'h02
`define CCIM_LEN_MLOADPC 6'h04
`define CCIM_LEN_MUL 6'h02
`define CCIM_LEN_LMUL 6'h03
// ---------------------------------------------------------------
// instruction fields
// ---------------------------------------------------------------
`define CCIM_MRS_HI 11
`define CCIM_MRS_LO 8
`define CCIM_TMRS_HI 2
`define CCIM_TMRS_LO 0
`define CCIM_PC_REG 4'hf
`endif

/* verilog/ccim_cycle_model.v */
// cycle and interlock sequencer of a five-stage core: takes one decoded
// instruction at a time, plays out its cycles on the instruction and data
// bus codes, inserts load-use interlocks and stops fetching while they last.
// assumes decode, memory wait and coprocessor busy come from the same clock.
`include "ccim_consts.vh"
module ccim_cycle_model
(
   input wire MCLK_I,
   input wire SYS_RST_I,
   input wire ISSUE_VALID_I,
   output wire ISSUE_READY_O,
   input wire [3:0] ISSUE_CLASS_I,
   input wire [31:0] INSTR_I,
   input wire COMPRESSED_I,
   input wire PC_DEST_I,
   input wire REG_SHIFT_I,
   input wire SUB_WORD_I,
   input wire FLAGS_ONLY_I,
   input wire UNSIGNED_MUL_I,
   input wire [3:0] LOAD_DEST_I,
   input wire [15:0] REG_LIST_I,
   input wire [4:0] CP_WORDS_I,
   output wire [3:0] MUL_OPND_SEL_O,
   input wire [31:0] MUL_OPND_I,
   input wire [3:0] NEXT_SRC_A_I,
   input wire [3:0] NEXT_SRC_B_I,
   input wire [1:0] NEXT_SRC_VALID_I,
   input wire MEM_WAIT_I,
   input wire CP_BUSY_I,
   output wire FETCH_EN_O,
   output wire INTERLOCK_O,
   output reg [1:0] IBUS_CYC_O,
   output reg [1:0] DBUS_CYC_O,
   output reg XFER_VALID_O,
   output reg [3:0] XFER_REG_O,
   output reg DONE_O,
   output reg [7:0] CYCLE_COUNT_O
);

// ---------------------------------------------------------------
// state
// ---------------------------------------------------------------
localparam ST_IDLE = 1'b0; // no instruction in flight
localparam ST_RUN = 1'b1; // playing out an instruction

reg state; // sequencer state
reg [3:0] cls; // class of the instruction in flight
reg [5:0] len; // main cycles, interlock included
reg [5:0] ilk; // interlock cycles at the tail
reg [5:0] idx; // main cycle index
reg [4:0] nxf; // words moved on the data bus
reg pcf; // instruction writes the pc
reg first; // very first cycle of the instruction
reg cpw; // still inside coprocessor busy-wait
reg mone; // single-register multiple load, no pc
reg [15:0] rem; // multiple load/store registers not yet moved
reg [7:0] tally; // total cycles spent so far

// ---------------------------------------------------------------
// register list scans
// ---------------------------------------------------------------
wire [4:0] lsum [0:16]; // running popcount of the list
wire [15:0] below; // some remaining bit lower than i
wire [15:0] above; // some list bit higher than i
wire [3:0] lo_enc [0:16]; // lowest remaining register
wire [3:0] hi_enc [0:16]; // highest listed register

assign lsum[0] = 5'h00;
assign lo_enc[0] = 4'h0;
assign hi_enc[0] = 4'h0;

genvar gi;
generate
   for (gi = 0; gi < 16; gi = gi + 1)
   begin : g_scan
      // population count of the incoming list
      assign lsum[gi + 1] = lsum[gi] + {4'h0, REG_LIST_I[gi]};
      // priority chains from the bottom and from the top
      if (gi == 0)
      begin : g_b0
         assign below[gi] = 1'b0;
      end
      else
      begin : g_bn
         assign below[gi] = below[gi - 1] | rem[gi - 1];
      end
      if (gi == 15)
      begin : g_a15
         assign above[gi] = 1'b0;
      end
      else
      begin : g_an
         assign above[gi] = above[gi + 1] | REG_LIST_I[gi + 1];
      end
      // register number of this bit, at the width of the encoders
      localparam [3:0] BIT_IDX = gi;
      assign lo_enc[gi + 1] = (rem[gi] & ~below[gi]) ? BIT_IDX : lo_enc[gi];
      assign hi_enc[gi + 1] = (REG_LIST_I[gi] & ~above[gi]) ? BIT_IDX : hi_enc[gi];
   end
endgenerate

wire [4:0] n_regs = lsum[16]; // registers in the list
wire [3:0] lo_reg = lo_enc[16]; // next register to move
wire [3:0] last_reg = hi_enc[16]; // register moved last

// ---------------------------------------------------------------
// dependency check against the instruction in decode
// ---------------------------------------------------------------
// true when the following instruction reads register r
function uses_reg;
   input [3:0] r;
   input [3:0] a;
   input [3:0] b;
   input [1:0] v;
   begin
      uses_reg = (v[0] & (a == r)) | (v[1] & (b == r));
   end
endfunction

wire use_dest = uses_reg(LOAD_DEST_I, NEXT_SRC_A_I, NEXT_SRC_B_I,
                         NEXT_SRC_VALID_I);
wire use_last = uses_reg(last_reg, NEXT_SRC_A_I, NEXT_SRC_B_I,
                         NEXT_SRC_VALID_I);

// ---------------------------------------------------------------
// multiplier early termination
// ---------------------------------------------------------------
assign MUL_OPND_SEL_O = COMPRESSED_I ?
   {1'b0, INSTR_I[`CCIM_TMRS_HI:`CCIM_TMRS_LO]} :
   INSTR_I[`CCIM_MRS_HI:`CCIM_MRS_LO];

// sign-extension counts as early end; short multiplies are never unsigned
wire sgn = ~UNSIGNED_MUL_I | (ISSUE_CLASS_I == `CCIM_CLS_MUL);
wire top8 = (MUL_OPND_I[31:8] == 24'h000000) |
            (sgn & (MUL_OPND_I[31:8] == 24'hffffff));
wire top16 = (MUL_OPND_I[31:16] == 16'h0000) |
             (sgn & (MUL_OPND_I[31:16] == 16'hffff));
wire top24 = (MUL_OPND_I[31:24] == 8'h00) |
             (sgn & (MUL_OPND_I[31:24] == 8'hff));
wire [5:0] mcyc = top8 ? 6'h01 : (top16 ? 6'h02 : (top24 ? 6'h03 : 6'h04));

// ---------------------------------------------------------------
// length and interlock of the offered instruction
// ---------------------------------------------------------------
reg [5:0] new_len; // main cycles
reg [5:0] new_ilk; // interlock cycles inside new_len
reg [4:0] new_nxf; // data words moved
reg new_pc; // pc written, fetch redirect at the end
reg new_cp; // coprocessor class, waits on busy

always @*
begin
   new_len = `CCIM_LEN_ONE;
   new_ilk = 6'h00;
   new_nxf = 5'h00;
   new_pc = 1'b0;
   new_cp = 1'b0;
   case (ISSUE_CLASS_I)
      `CCIM_CLS_DATA:
      begin
         // shift adds one, pc adds two
         new_len = `CCIM_LEN_ONE + {5'h00, REG_SHIFT_I} +
                   (PC_DEST_I ? `CCIM_LEN_PCEXTRA : 6'h00);
         new_pc = PC_DEST_I;
      end
      `CCIM_CLS_LOAD:
      begin
         new_nxf = 5'h01;
         if (PC_DEST_I)
         begin
            new_len = `CCIM_LEN_LOADPC;
            new_pc = 1'b1;
         end
         else if (use_dest)
         begin
            // rotation of sub-word data costs a second interlock cycle
            new_ilk = SUB_WORD_I ? 6'h02 : 6'h01;
            new_len = `CCIM_LEN_ONE + new_ilk;
         end
         else
         begin
            new_len = `CCIM_LEN_ONE;
         end
      end
      `CCIM_CLS_STORE:
      begin
         new_nxf = 5'h01;
         new_len = `CCIM_LEN_ONE;
      end
      `CCIM_CLS_MLOAD, `CCIM_CLS_MSTORE:
      begin
         new_nxf = n_regs;
         if ((ISSUE_CLASS_I == `CCIM_CLS_MLOAD) && REG_LIST_I[`CCIM_PC_REG])
         begin
            new_len = {1'b0, n_regs} + `CCIM_LEN_MLOADPC;
            new_pc = 1'b1;
         end
         else
         begin
            new_len = (n_regs == 5'h01) ? `CCIM_LEN_TWO : {1'b0, n_regs};
            // earlier registers are ready once the final fetch starts,
            // only the last one costs an extra cycle
            if ((ISSUE_CLASS_I == `CCIM_CLS_MLOAD) && use_last)
            begin
               new_ilk = 6'h01;
               new_len = new_len + 6'h01;
            end
         end
      end
      `CCIM_CLS_WSWAP:
      begin
         new_nxf = 5'h02;
         new_ilk = {5'h00, use_dest};
         new_len = `CCIM_LEN_TWO + new_ilk;
      end
      `CCIM_CLS_BSWAP:
      begin
         new_nxf = 5'h02;
         new_ilk = 6'h01;
         new_len = `CCIM_LEN_THREE;
      end
      `CCIM_CLS_CDP, `CCIM_CLS_MCR:
      begin
         new_cp = 1'b1;
         new_len = `CCIM_LEN_ONE;
      end
      `CCIM_CLS_MRC:
      begin
         new_cp = 1'b1;
         new_ilk = {5'h00, use_dest};
         new_len = `CCIM_LEN_ONE + new_ilk;
      end
      `CCIM_CLS_CLDST:
      begin
         new_cp = 1'b1;
         new_nxf = CP_WORDS_I;
         new_len = {1'b0, CP_WORDS_I};
      end
      `CCIM_CLS_MRS:
      begin
         new_len = `CCIM_LEN_ONE;
      end
      `CCIM_CLS_MSR:
      begin
         new_len = FLAGS_ONLY_I ? `CCIM_LEN_ONE : `CCIM_LEN_THREE;
      end
      `CCIM_CLS_MUL:
      begin
         new_len = `CCIM_LEN_MUL + mcyc;
      end
      `CCIM_CLS_LMUL:
      begin
         new_len = `CCIM_LEN_LMUL + mcyc;
      end
      default:
      begin
         new_len = `CCIM_LEN_ONE;
      end
   endcase
end

// ---------------------------------------------------------------
// cycle advance and handshake
// ---------------------------------------------------------------
wire busy_cyc = (state == ST_RUN) & cpw & CP_BUSY_I;
wire stall = MEM_WAIT_I;
wire advance = (state == ST_RUN) & ~stall & ~busy_cyc;
wire last = advance & (idx == len - 6'h01);
wire in_ilk = (state == ST_RUN) & ~busy_cyc & (idx >= len - ilk) & (ilk != 6'h00);
wire accept = ISSUE_VALID_I & ISSUE_READY_O;

assign ISSUE_READY_O = (state == ST_IDLE) | last;
assign INTERLOCK_O = in_ilk;
// decode and fetch hold while the bubble goes down the pipe
assign FETCH_EN_O = ~in_ilk & ~stall;

// ---------------------------------------------------------------
// bus cycle codes for the current cycle
// ---------------------------------------------------------------
reg [1:0] ib; // instruction bus code
reg [1:0] db; // data bus code
reg xv; // a list register moves this cycle

always @*
begin
   ib = `CCIM_BUS_I;
   db = `CCIM_BUS_I;
   xv = 1'b0;
   // instruction side: one S, then I, pc writers end with N then S
   if (first)
   begin
      ib = `CCIM_BUS_S;
   end
   else if (pcf & ~busy_cyc & (idx == len - 6'h02))
   begin
      ib = `CCIM_BUS_N;
   end
   else if (pcf & ~busy_cyc & (idx == len - 6'h01))
   begin
      ib = `CCIM_BUS_S;
   end
   // data side
   if (busy_cyc)
   begin
      db = `CCIM_BUS_I;
   end
   else
   begin
      case (cls)
         `CCIM_CLS_LOAD, `CCIM_CLS_STORE, `CCIM_CLS_WSWAP, `CCIM_CLS_BSWAP:
         begin
            db = ({1'b0, idx} < {1'b0, nxf}) ? `CCIM_BUS_N : `CCIM_BUS_I;
         end
         `CCIM_CLS_MLOAD, `CCIM_CLS_MSTORE, `CCIM_CLS_CLDST:
         begin
            if ({1'b0, idx} < {1'b0, nxf})
            begin
               // first word N, rest S; a lone plain load is S
               db = ((idx == 6'h00) & ~mone) ? `CCIM_BUS_N : `CCIM_BUS_S;
               xv = (cls != `CCIM_CLS_CLDST);
            end
         end
         `CCIM_CLS_MCR, `CCIM_CLS_MRC:
         begin
            db = (idx == 6'h00) ? `CCIM_BUS_C : `CCIM_BUS_I;
         end
         default:
         begin
            db = `CCIM_BUS_I;
         end
      endcase
   end
   if (state == ST_IDLE)
   begin
      ib = `CCIM_BUS_I;
      db = `CCIM_BUS_I;
      xv = 1'b0;
   end
end

// ---------------------------------------------------------------
// sequencer registers
// ---------------------------------------------------------------
always @(posedge MCLK_I or posedge SYS_RST_I)
begin
   if (SYS_RST_I)
   begin
      state <= ST_IDLE;
      cls <= `CCIM_CLS_DATA;
      len <= `CCIM_LEN_ONE;
      ilk <= 6'h00;
      idx <= 6'h00;
      nxf <= 5'h00;
      pcf <= 1'b0;
      first <= 1'b0;
      cpw <= 1'b0;
      mone <= 1'b0;
      rem <= 16'h0000;
      tally <= 8'h00;
   end
   else
   begin
      if (accept)
      begin
         // take the next instruction, possibly in the last cycle of this one
         state <= ST_RUN;
         cls <= ISSUE_CLASS_I;
         len <= new_len;
         ilk <= new_ilk;
         idx <= 6'h00;
         nxf <= new_nxf;
         pcf <= new_pc;
         first <= 1'b1;
         cpw <= new_cp;
         mone <= (ISSUE_CLASS_I == `CCIM_CLS_MLOAD) & (n_regs == 5'h01) &
                 ~REG_LIST_I[`CCIM_PC_REG];
         rem <= REG_LIST_I;
         tally <= 8'h00;
      end
      else if (state == ST_RUN)
      begin
         // any cycle, waits included, counts toward the total
         tally <= tally + 8'h01;
         if (~stall)
         begin
            first <= 1'b0;
         end
         if (~stall & ~CP_BUSY_I)
         begin
            cpw <= 1'b0;
         end
         if (advance)
         begin
            idx <= idx + 6'h01;
            if (xv)
            begin
               rem <= rem & ~(16'h0001 << lo_reg);
            end
         end
         if (last)
         begin
            state <= ST_IDLE;
         end
      end
   end
end

// ---------------------------------------------------------------
// registered outputs, one cycle behind the cycle they describe
// ---------------------------------------------------------------
always @(posedge MCLK_I or posedge SYS_RST_I)
begin
   if (SYS_RST_I)
   begin
      IBUS_CYC_O <= `CCIM_BUS_I;
      DBUS_CYC_O <= `CCIM_BUS_I;
      XFER_VALID_O <= 1'b0;
      XFER_REG_O <= 4'h0;
      DONE_O <= 1'b0;
      CYCLE_COUNT_O <= 8'h00;
   end
   else
   begin
      IBUS_CYC_O <= stall ? `CCIM_BUS_I : ib;
      DBUS_CYC_O <= stall ? `CCIM_BUS_I : db;
      XFER_VALID_O <= xv & advance;
      XFER_REG_O <= lo_reg;
      DONE_O <= last;
      if (last)
      begin
         CYCLE_COUNT_O <= tally + 8'h01;
      end
   end
end

endmodule
